// >>> rtl/css_top.sv
// Control source select: pin decoders, function muxes, register slave and switchover.
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.svh"
module css_top
    import css_pkg::*;
(
    input  wire logic          MCLK,
    input  wire logic          RESET,
    input  wire logic [3:0]    IN_FREQ_SEL,
    input  wire logic [5:0]    OUT_FREQ_SEL,
    input  wire logic [2:0]    SHARED_SERIAL_OUTMODE_PINS,
    output logic [2:0]         SERIAL_PORT_PINS,
    output logic [2:0]         OUTPUT_MODE_BITS,
    output logic               SERIAL_MODE,
    input  wire logic          PRIMARY_REF_OK,
    input  wire logic          SECONDARY_REF_OK,
    input  wire logic          CRYSTAL_OK,
    input  wire logic          FORCE_SECONDARY,
    output css_sel_t           REF_SELECT,
    output css_ref_path_t      PRIMARY_REF_PATH,
    output css_ref_path_t      SECONDARY_REF_PATH,
    output logic               SECONDARY_ACTIVE,
    output logic [13:0]        CRYSTAL_RDIV,
    output logic               CRYSTAL_DOUBLE,
    output logic [19:0]        FEEDBACK_DIV,
    output css_out_div_t       OUTPUT_DIVIDERS,
    output logic               VCO_CAL_START,
    input  wire logic          WB_CYC_I,
    input  wire logic          WB_STB_I,
    input  wire logic          WB_WE_I,
    input  wire logic [7:0]    WB_ADR_I,
    input  wire logic [3:0]    WB_SEL_I,
    input  wire logic [31:0]   WB_DAT_I,
    output logic [31:0]        WB_DAT_O,
    output logic               WB_ACK_O
);

    // ------------------------------------------------------------------
    // Pin decoders
    // ------------------------------------------------------------------
    function automatic css_out_div_t pin_out_div(input logic [5:0] y);
        css_out_div_t d;
        d = '{1'b1, 10'h001, 10'h001};
        case (y)
            6'h01: d = '{1'b0, 10'h003, 10'h003};
            6'h02: d = '{1'b0, 10'h003, 10'h006};
            6'h03: d = '{1'b0, 10'h003, 10'h00c};
            6'h04: d = '{1'b0, 10'h003, 10'h02d};
            6'h05: d = '{1'b0, 10'h003, 10'h168};
            6'h06: d = '{1'b0, 10'h003, 10'h1e0};
            6'h07: d = '{1'b0, 10'h006, 10'h006};
            6'h08: d = '{1'b0, 10'h006, 10'h00c};
            6'h09: d = '{1'b0, 10'h006, 10'h02d};
            6'h0a: d = '{1'b0, 10'h006, 10'h168};
            6'h0b: d = '{1'b0, 10'h006, 10'h1e0};
            6'h0c: d = '{1'b0, 10'h00c, 10'h00c};
            6'h0d: d = '{1'b0, 10'h00c, 10'h02d};
            6'h0e: d = '{1'b0, 10'h00c, 10'h168};
            6'h0f: d = '{1'b0, 10'h00c, 10'h1e0};
            6'h10: d = '{1'b0, 10'h02d, 10'h02d};
            6'h11: d = '{1'b0, 10'h02d, 10'h168};
            6'h12: d = '{1'b0, 10'h02d, 10'h1e0};
            6'h13: d = '{1'b0, 10'h168, 10'h168};
            6'h14: d = '{1'b0, 10'h168, 10'h1e0};
            6'h15: d = '{1'b0, 10'h1e0, 10'h1e0};
            6'h16: d = '{1'b1, 10'h004, 10'h004};
            6'h17: d = '{1'b1, 10'h004, 10'h005};
            6'h18: d = '{1'b1, 10'h004, 10'h019};
            6'h19: d = '{1'b1, 10'h005, 10'h005};
            6'h1a: d = '{1'b1, 10'h005, 10'h019};
            6'h1b: d = '{1'b1, 10'h019, 10'h019};
            6'h1c: d = '{1'b1, 10'h004, 10'h004};
            6'h1d: d = '{1'b1, 10'h004, 10'h008};
            6'h1e: d = '{1'b1, 10'h004, 10'h020};
            6'h1f: d = '{1'b1, 10'h008, 10'h008};
            6'h20: d = '{1'b1, 10'h008, 10'h020};
            6'h21: d = '{1'b1, 10'h020, 10'h020};
            6'h22: d = '{1'b1, 10'h004, 10'h004};
            6'h23: d = '{1'b1, 10'h004, 10'h005};
            6'h24: d = '{1'b1, 10'h004, 10'h00a};
            6'h25: d = '{1'b1, 10'h004, 10'h12c};
            6'h26: d = '{1'b1, 10'h004, 10'h190};
            6'h27: d = '{1'b1, 10'h006, 10'h006};
            6'h28: d = '{1'b1, 10'h006, 10'h00c};
            6'h29: d = '{1'b1, 10'h006, 10'h018};
            6'h2a: d = '{1'b1, 10'h00c, 10'h00c};
            6'h2b: d = '{1'b1, 10'h00c, 10'h018};
            6'h2c: d = '{1'b1, 10'h190, 10'h190};
            6'h2d: d = '{1'b1, 10'h001, 10'h001};
            6'h2e: d = '{1'b1, 10'h001, 10'h002};
            6'h2f: d = '{1'b1, 10'h001, 10'h004};
            6'h30: d = '{1'b1, 10'h002, 10'h002};
            6'h31: d = '{1'b1, 10'h002, 10'h004};
            6'h32: d = '{1'b1, 10'h004, 10'h004};
            6'h33: d = '{1'b1, 10'h001, 10'h001};
            default: d = '{1'b1, 10'h001, 10'h001};
        endcase
        return d;
    endfunction : pin_out_div

    function automatic logic [19:0] pin_feedback(input logic [3:0] a, input logic [5:0] y);
        logic [19:0] n;
        logic        hi;
        n  = `CSS_RST_NDIV;
        hi = (a == 4'hf);
        if (a == 4'hd && y >= 6'h2d && y <= 6'h32) begin
            n = 20'h005e8;
        end else if (a == 4'he && y == 6'h33) begin
            n = 20'h00300;
        end else if (a == 4'hd || a == 4'he || y > 6'h2c) begin
            n = `CSS_RST_NDIV;
        end else if (y <= 6'h15 || (y >= 6'h22 && y <= 6'h26)) begin
            n = hi ? 20'h43800 : 20'h38400;
        end else if (y <= 6'h1b) begin
            n = hi ? 20'h44aa2 : 20'h39387;
        end else if (y <= 6'h21) begin
            n = hi ? 20'h44580 : 20'h38f40;
        end else if (y <= 6'h2b) begin
            n = hi ? 20'h41eb0 : 20'h36ee8;
        end else begin
            n = hi ? 20'h43da0 : 20'h388b0;
        end
        return n;
    endfunction : pin_feedback

    logic         serial_mode;
    css_out_div_t pin_div;
    logic [19:0]  pin_ndiv;

    assign serial_mode = (IN_FREQ_SEL == 4'h0) || (OUT_FREQ_SEL == 6'h00);
    assign pin_div     = pin_out_div(OUT_FREQ_SEL);
    assign pin_ndiv    = pin_feedback(IN_FREQ_SEL, OUT_FREQ_SEL);
    assign SERIAL_MODE = serial_mode;

    // ------------------------------------------------------------------
    // Shared pin routing
    // ------------------------------------------------------------------
    assign SERIAL_PORT_PINS = serial_mode ? SHARED_SERIAL_OUTMODE_PINS : 3'h0;
    assign OUTPUT_MODE_BITS = serial_mode ? 3'h0 : SHARED_SERIAL_OUTMODE_PINS;

    // ------------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------------
    logic        req;
    logic        wr;
    logic [5:0]  idx;
    logic        cal_en;
    logic        out_en;
    logic        ref_en;
    logic        diff_mode;
    logic [3:0]  ref_opts;
    logic        reg_div6;
    logic [9:0]  reg_p1;
    logic [9:0]  reg_p2;
    logic [1:0]  sw_mode;
    logic [13:0] reg_rdiv_a;
    logic [13:0] reg_rdiv_b;
    logic [13:0] reg_rdiv_x;
    logic [19:0] reg_ndiv;
    logic [31:0] next_rdata;
    css_sel_t    sel;
    css_sel_t    next_sel;

    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign idx = WB_ADR_I[7:2];
    assign wr  = req && WB_WE_I && WB_SEL_I[0] && serial_mode;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= req;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cal_en <= `CSS_RST_EN;
            out_en <= `CSS_RST_EN;
            ref_en <= `CSS_RST_EN;
        end else if (wr) begin
            if (idx == `CSS_IDX_VCO_CAL) begin
                cal_en <= WB_DAT_I[`CSS_CAL_EN_BIT];
            end else if (idx == `CSS_IDX_OUT_EN) begin
                out_en <= WB_DAT_I[`CSS_OUT_EN_BIT];
            end else if (idx == `CSS_IDX_REF_CTRL) begin
                ref_en <= WB_DAT_I[`CSS_REF_EN_BIT];
            end
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            reg_div6   <= 1'b0;
            reg_p1     <= `CSS_RST_P;
            reg_p2     <= `CSS_RST_P;
            sw_mode    <= `CSS_RST_SWMODE;
            diff_mode  <= 1'b0;
            ref_opts   <= 4'h0;
            reg_rdiv_a <= `CSS_RST_RDIV;
            reg_rdiv_b <= `CSS_RST_RDIV;
            reg_rdiv_x <= `CSS_RST_RDIV;
            reg_ndiv   <= `CSS_RST_NDIV;
        end else if (wr) begin
            if (idx == `CSS_IDX_P1_LO) begin
                reg_p1[7:0] <= WB_DAT_I[7:0];
            end else if (idx == `CSS_IDX_P1_HI) begin
                reg_p1[9:8] <= WB_DAT_I[1:0];
            end else if (idx == `CSS_IDX_P2_LO) begin
                reg_p2[7:0] <= WB_DAT_I[7:0];
            end else if (idx == `CSS_IDX_P2_HI) begin
                reg_p2[9:8] <= WB_DAT_I[1:0];
                reg_div6    <= WB_DAT_I[`CSS_P0_BIT];
            end else if (idx == `CSS_IDX_SWITCH) begin
                sw_mode <= WB_DAT_I[7:6];
            end else if (idx == `CSS_IDX_REF_CTRL) begin
                diff_mode <= WB_DAT_I[`CSS_DIFF_BIT];
                ref_opts  <= WB_DAT_I[`CSS_DBL_B_BIT:`CSS_PRE_A_BIT];
            end else if (idx == `CSS_IDX_RDIV_A) begin
                reg_rdiv_a <= WB_DAT_I[13:0];
            end else if (idx == `CSS_IDX_RDIV_B) begin
                reg_rdiv_b <= WB_DAT_I[13:0];
            end else if (idx == `CSS_IDX_RDIV_X) begin
                reg_rdiv_x <= WB_DAT_I[13:0];
            end else if (idx == `CSS_IDX_NDIV) begin
                reg_ndiv <= WB_DAT_I[19:0];
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        if (!serial_mode) begin
            next_rdata = 32'h0;
        end else if (idx == `CSS_IDX_VCO_CAL) begin
            next_rdata = {29'h0, cal_en, 2'h0};
        end else if (idx == `CSS_IDX_OUT_EN) begin
            next_rdata = {29'h0, out_en, 2'h0};
        end else if (idx == `CSS_IDX_P1_LO) begin
            next_rdata = {24'h0, reg_p1[7:0]};
        end else if (idx == `CSS_IDX_P1_HI) begin
            next_rdata = {30'h0, reg_p1[9:8]};
        end else if (idx == `CSS_IDX_P2_LO) begin
            next_rdata = {24'h0, reg_p2[7:0]};
        end else if (idx == `CSS_IDX_P2_HI) begin
            next_rdata = {24'h0, reg_div6, 5'h0, reg_p2[9:8]};
        end else if (idx == `CSS_IDX_SWITCH) begin
            next_rdata = {24'h0, sw_mode, 6'h0};
        end else if (idx == `CSS_IDX_REF_CTRL) begin
            next_rdata = {26'h0, ref_opts, diff_mode, ref_en};
        end else if (idx == `CSS_IDX_RDIV_A) begin
            next_rdata = {18'h0, reg_rdiv_a};
        end else if (idx == `CSS_IDX_RDIV_B) begin
            next_rdata = {18'h0, reg_rdiv_b};
        end else if (idx == `CSS_IDX_RDIV_X) begin
            next_rdata = {18'h0, reg_rdiv_x};
        end else if (idx == `CSS_IDX_NDIV) begin
            next_rdata = {12'h0, reg_ndiv};
        end else if (idx == `CSS_IDX_STATUS) begin
            next_rdata = {24'h0, CRYSTAL_OK, SECONDARY_REF_OK, PRIMARY_REF_OK, 2'h0, sel, 1'b1};
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            WB_DAT_O <= 32'h0;
        end else if (req && !WB_WE_I) begin
            WB_DAT_O <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Function muxes
    // ------------------------------------------------------------------
    css_ref_path_t pin_ref;
    css_ref_path_t reg_ref [2];
    css_ref_path_t path    [2];

    assign pin_ref    = '{1'b0, 1'b0, `CSS_PIN_RDIV};
    assign reg_ref[0] = '{ref_opts[0], ref_opts[1], reg_rdiv_a};
    assign reg_ref[1] = '{ref_opts[2], ref_opts[3], reg_rdiv_b};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ref
            assign path[g] = ref_en ? reg_ref[g] : pin_ref;
        end
    endgenerate

    assign PRIMARY_REF_PATH   = path[0];
    assign SECONDARY_REF_PATH = path[1];
    assign SECONDARY_ACTIVE   = !(ref_en && diff_mode);
    assign CRYSTAL_DOUBLE     = 1'b1;
    assign CRYSTAL_RDIV       = ref_en ? reg_rdiv_x : `CSS_PIN_RDIV;
    assign FEEDBACK_DIV       = ref_en ? reg_ndiv : pin_ndiv;
    assign OUTPUT_DIVIDERS    = out_en ? '{reg_div6, reg_p1, reg_p2} : pin_div;

    // ------------------------------------------------------------------
    // VCO calibration
    // ------------------------------------------------------------------
    logic [40:0] pin_snap;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pin_snap      <= 41'h0;
            VCO_CAL_START <= 1'b0;
        end else begin
            pin_snap <= {pin_div, pin_ndiv};
            if (wr && idx == `CSS_IDX_VCO_CAL) begin
                VCO_CAL_START <= WB_DAT_I[`CSS_CAL_GO_BIT] && WB_DAT_I[`CSS_CAL_EN_BIT];
            end else begin
                VCO_CAL_START <= !cal_en && (pin_snap != {pin_div, pin_ndiv});
            end
        end
    end

    // ------------------------------------------------------------------
    // Switchover
    // ------------------------------------------------------------------
    logic b_ok;

    assign b_ok = SECONDARY_REF_OK && SECONDARY_ACTIVE;

    always_comb begin
        next_sel = SEL_NONE;
        case (sw_mode)
            2'h2: begin
                if (FORCE_SECONDARY && b_ok) next_sel = SEL_SECONDARY;
                else if (PRIMARY_REF_OK) next_sel = SEL_PRIMARY;
            end
            2'h3: begin
                if (b_ok) next_sel = SEL_SECONDARY;
            end
            default: begin
                if (FORCE_SECONDARY && b_ok) next_sel = SEL_SECONDARY;
                else if (sw_mode == 2'h1 && sel == SEL_SECONDARY && b_ok) next_sel = SEL_SECONDARY;
                else if (PRIMARY_REF_OK) next_sel = SEL_PRIMARY;
                else if (b_ok) next_sel = SEL_SECONDARY;
                else if (CRYSTAL_OK) next_sel = SEL_CRYSTAL;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sel <= SEL_NONE;
        end else begin
            sel <= next_sel;
        end
    end

    assign REF_SELECT = sel;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_serial_mode;
        @(posedge MCLK) disable iff (RESET)
        SERIAL_MODE == ((IN_FREQ_SEL == 4'h0) || (OUT_FREQ_SEL == 6'h00));
    endproperty
    a_serial_mode: assert property (p_serial_mode) else $error("serial mode decode wrong");

    property p_routing;
        @(posedge MCLK) disable iff (RESET)
        SERIAL_MODE ? (SERIAL_PORT_PINS == SHARED_SERIAL_OUTMODE_PINS && OUTPUT_MODE_BITS == 3'h0)
                    : (OUTPUT_MODE_BITS == SHARED_SERIAL_OUTMODE_PINS && SERIAL_PORT_PINS == 3'h0);
    endproperty
    a_routing: assert property (p_routing) else $error("shared pins misrouted");

    property p_no_write_outside;
        @(posedge MCLK) disable iff (RESET)
        !SERIAL_MODE |=> $stable(out_en) && $stable(reg_p1) && $stable(ref_en);
    endproperty
    a_no_write_outside: assert property (p_no_write_outside) else $error("write taken outside serial mode");

    property p_mux_select;
        @(posedge MCLK) disable iff (RESET)
        out_en |-> OUTPUT_DIVIDERS == {reg_div6, reg_p1, reg_p2};
    endproperty
    a_mux_select: assert property (p_mux_select) else $error("divider mux not on registers");

    property p_pin_select;
        @(posedge MCLK) disable iff (RESET)
        !ref_en |-> FEEDBACK_DIV == pin_ndiv && PRIMARY_REF_PATH == pin_ref;
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("mux not on pin decoders");

    property p_enable_write;
        @(posedge MCLK) disable iff (RESET)
        wr && idx == `CSS_IDX_OUT_EN |=> out_en == $past(WB_DAT_I[`CSS_OUT_EN_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("divider enable not written");

    property p_cal_cmd;
        @(posedge MCLK) disable iff (RESET)
        wr && idx == `CSS_IDX_VCO_CAL && WB_DAT_I[7] && WB_DAT_I[2] |=> VCO_CAL_START ##1 !VCO_CAL_START;
    endproperty
    a_cal_cmd: assert property (p_cal_cmd) else $error("calibration command lost");

    property p_diff_inactive;
        @(posedge MCLK) disable iff (RESET)
        ref_en && diff_mode |=> REF_SELECT != SEL_SECONDARY;
    endproperty
    a_diff_inactive: assert property (p_diff_inactive) else $error("secondary used in differential mode");

    property p_holdover;
        @(posedge MCLK) disable iff (RESET)
        sw_mode[1] == 1'b0 && !PRIMARY_REF_OK && !SECONDARY_REF_OK && CRYSTAL_OK |=> REF_SELECT == SEL_CRYSTAL;
    endproperty
    a_holdover: assert property (p_holdover) else $error("holdover not entered");

    property p_ack;
        @(posedge MCLK) disable iff (RESET)
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong");

endmodule : css_top
`default_nettype wire

// >>> rtl/css_defines.svh
// Constants of the control source select block.
// Behaviour
// - Serial mode is high when either selection pin group is all zeros.
// - Shared pins go to the serial side in serial mode, else to the decoder.
// - Serial mode blocks output-mode pins; otherwise serial register writes are ignored.
// - Every function takes its bits through its own mux under one enable bit.
// - All enable bits are zero after reset, so pin decoders drive every function.
// - A mux switches to register bits in the same cycle its enable is set.
// - Output dividers live at 0x15 to 0x18, enabled by 0x14 bit 2.
// - 0x0E bit 2 gives calibration to registers; bit 7 issues calibration when written together with bit 2.
// - Register control persists outside serial mode until cleared in serial mode.
// - Each reference path has divide-by-5, doubler and 14-bit divider settings.
// - Single differential reference keeps the secondary path inactive.
// - Crystal path is a fixed doubler followed by a 14-bit divider.
// - Switchover modes 0 and 1 change reference on failure and fall to the crystal when both fail.
// - VCO prescaler divides by 5 or 6 as configured.
// - Two 10-bit output dividers follow the prescaler.
// - Feedback divider sets oscillator to phase detector frequency ratio.
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH
`define CSS_IDX_VCO_CAL   6'h0e
`define CSS_IDX_OUT_EN    6'h14
`define CSS_IDX_P1_LO     6'h15
`define CSS_IDX_P1_HI     6'h16
`define CSS_IDX_P2_LO     6'h17
`define CSS_IDX_P2_HI     6'h18
`define CSS_IDX_SWITCH    6'h29
`define CSS_IDX_REF_CTRL  6'h30
`define CSS_IDX_RDIV_A    6'h31
`define CSS_IDX_RDIV_B    6'h32
`define CSS_IDX_RDIV_X    6'h33
`define CSS_IDX_NDIV      6'h34
`define CSS_IDX_STATUS    6'h35
`define CSS_CAL_EN_BIT    2
`define CSS_CAL_GO_BIT    7
`define CSS_OUT_EN_BIT    2
`define CSS_P0_BIT        7
`define CSS_REF_EN_BIT    0
`define CSS_DIFF_BIT      1
`define CSS_PRE_A_BIT     2
`define CSS_DBL_A_BIT     3
`define CSS_PRE_B_BIT     4
`define CSS_DBL_B_BIT     5
`define CSS_RST_EN        1'b0
`define CSS_RST_P         10'h001
`define CSS_RST_RDIV      14'h0001
`define CSS_RST_NDIV      20'h00001
`define CSS_RST_SWMODE    2'h0
`define CSS_PIN_RDIV      14'h0001
`endif

// >>> rtl/css_pkg.sv
// Types of the control source select block.
package css_pkg;
    typedef struct packed {
        logic       div6;
        logic [9:0] p1;
        logic [9:0] p2;
    } css_out_div_t;
    typedef struct packed {
        logic        prescale5;
        logic        double;
        logic [13:0] rdiv;
    } css_ref_path_t;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_PRIMARY,
        SEL_SECONDARY,
        SEL_CRYSTAL
    } css_sel_t;
endpackage : css_pkg

// >>> tb/css_host.sv
// Host model: frequency select pins and register bus master.
`timescale 1ns/1ps
`default_nettype none
module css_host (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output logic      [3:0]  in_sel,
    output logic      [5:0]  out_sel,
    output logic      [2:0]  shared,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic      [7:0]  adr,
    output logic      [31:0] wdat
);
    initial begin
        in_sel = 4'h1;
        out_sel = 6'h02;
        shared = 3'h5;
        {cyc, stb, we, adr, wdat} = '0;
    end
    // Pin changes; serial mode is entered before any enable is written.
    task pins(input logic [3:0] a, input logic [5:0] y);
        @(posedge clk);
        in_sel <= a;
        out_sel <= y;
    endtask : pins
    // One classic cycle; released data goes to the inverse value.
    task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
              output logic [31:0] q);
        int n;
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {idx[5:0], 2'b00};
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        wdat <= ~{24'h0, d};
        if (n >= 20) tb.timeout();
    endtask : xfer
endmodule : css_host
`default_nettype wire

// >>> tb/tb.sv
// Testbench of the control source select block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import css_pkg::*;
    logic MCLK, RESET, p_ok, s_ok, x_ok, ack, cyc, stb, we, smode, sec_act, xdbl, cal;
    logic [3:0] a_sel;
    logic [5:0] y_sel;
    logic [2:0] sh, sp, om;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    css_sel_t sel;
    css_ref_path_t pa, pb;
    logic [13:0] xr;
    logic [19:0] fb;
    int cal_hits = 0;
    css_out_div_t od;
    int bad_count, checked;
    css_host u_host (.clk(MCLK), .ack(ack), .rdat(rdat), .in_sel(a_sel), .out_sel(y_sel),
        .shared(sh), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .wdat(wdat));
    css_top u_css_top (.MCLK(MCLK), .RESET(RESET), .IN_FREQ_SEL(a_sel), .OUT_FREQ_SEL(y_sel),
        .SHARED_SERIAL_OUTMODE_PINS(sh), .SERIAL_PORT_PINS(sp), .OUTPUT_MODE_BITS(om),
        .SERIAL_MODE(smode), .PRIMARY_REF_OK(p_ok), .SECONDARY_REF_OK(s_ok), .CRYSTAL_OK(x_ok),
        .FORCE_SECONDARY(1'b0), .REF_SELECT(sel), .PRIMARY_REF_PATH(pa),
        .SECONDARY_REF_PATH(pb), .SECONDARY_ACTIVE(sec_act), .CRYSTAL_RDIV(xr),
        .CRYSTAL_DOUBLE(xdbl), .FEEDBACK_DIV(fb), .OUTPUT_DIVIDERS(od), .VCO_CAL_START(cal),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
    // Counts calibration pulses while they stand, since a pulse lasts one cycle only.
    always @(negedge MCLK) begin
        if (cal === 1'b1) begin
            cal_hits++;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task tally_and_finish();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task timeout();
        bad_count++;
        tally_and_finish();
    endtask : timeout
    task t_pins();
        for (int i = 0; i < 4; i++) begin
            u_host.pins(i[0] ? 4'h0 : 4'h1, i[1] ? 6'h00 : 6'h02);
            @(negedge MCLK);
            chk("serial_mode", 32'(i != 0), 32'(smode));
            chk("serial_pins", (i != 0) ? 32'h5 : 32'h0, 32'(sp));
            chk("mode_bits", (i != 0) ? 32'h0 : 32'h5, 32'(om));
            if (i == 0) begin
                chk("out_div", 32'({1'b0, 10'h003, 10'h006}), 32'(od));
                chk("ref_path", 32'h1, 32'(pa));
                chk("crystal_input_dbl", 32'h1, 32'(xdbl));
                chk("fb_div", 32'h38400, 32'(fb));
            end
        end
    endtask : t_pins
    task t_regs();
        u_host.pins(4'h0, 6'h02);
        u_host.xfer(1'b1, 8'h15, 8'h23, q);
        u_host.xfer(1'b1, 8'h16, 8'h01, q);
        u_host.xfer(1'b1, 8'h17, 8'h45, q);
        u_host.xfer(1'b1, 8'h18, 8'h82, q);
        u_host.xfer(1'b1, 8'h14, 8'h04, q);
        @(negedge MCLK);
        chk("reg_div", 32'({1'b1, 10'h123, 10'h245}), 32'(od));
        u_host.pins(4'h1, 6'h02);
        u_host.xfer(1'b1, 8'h14, 8'h00, q);
        u_host.xfer(1'b0, 8'h14, 8'h00, q);
        chk("rd_outside", 32'h0, q);
        @(negedge MCLK);
        chk("held_div", 32'({1'b1, 10'h123, 10'h245}), 32'(od));
        u_host.pins(4'h0, 6'h02);
        u_host.xfer(1'b1, 8'h14, 8'h00, q);
        u_host.pins(4'h1, 6'h02);
        @(negedge MCLK);
        chk("pin_div", 32'({1'b0, 10'h003, 10'h006}), 32'(od));
    endtask : t_regs
    task t_cal();
        int hits;
        u_host.pins(4'h0, 6'h02);
        repeat (4) @(posedge MCLK);
        hits = cal_hits;
        u_host.xfer(1'b1, 8'h0e, 8'h84, q);
        repeat (4) @(negedge MCLK);
        chk("cal_pulse", 32'h1, 32'(cal_hits - hits));
        u_host.xfer(1'b0, 8'h0e, 8'h00, q);
        chk("cal_reg", 32'h4, q);
        u_host.xfer(1'b0, 8'h3f, 8'h00, q);
        chk("unmapped", 32'h0, q);
        u_host.xfer(1'b1, 8'h33, 8'h09, q);
        u_host.xfer(1'b1, 8'h30, 8'h2f, q);
        @(negedge MCLK);
        chk("sec_active", 32'h0, 32'(sec_act));
        chk("ref_a", 32'hc001, 32'(pa));
        chk("ref_b", 32'h4001, 32'(pb));
        chk("crystal_input_rdiv", 32'h9, 32'(xr));
        chk("fb_reg", 32'h1, 32'(fb));
        u_host.xfer(1'b1, 8'h30, 8'h00, q);
        @(negedge MCLK);
        chk("sec_back", 32'h1, 32'(sec_act));
        chk("ref_pin", 32'h1, 32'(pa));
    endtask : t_cal
    task t_switch();
        logic [2:0] ok [7] = '{3'h7, 3'h6, 3'h4, 3'h7, 3'h6, 3'h7, 3'h5};
        css_sel_t exp [7] = '{SEL_PRIMARY, SEL_SECONDARY, SEL_CRYSTAL, SEL_PRIMARY,
                              SEL_SECONDARY, SEL_SECONDARY, SEL_PRIMARY};
        for (int i = 0; i < 7; i++) begin
            if (i == 4) begin
                u_host.xfer(1'b1, 8'h29, 8'h40, q);
            end
            @(posedge MCLK);
            {x_ok, s_ok, p_ok} <= ok[i];
            repeat (2) @(negedge MCLK);
            chk("ref_select", 32'(exp[i]), 32'(sel));
        end
    endtask : t_switch
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    initial begin
        RESET = 1'b1;
        {p_ok, s_ok, x_ok} = 3'h0;
        bad_count = 0;
        checked = 0;
        repeat (10) @(posedge MCLK);
        RESET <= 1'b0;
        t_pins();
        t_regs();
        t_cal();
        t_switch();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
